// [rtl/uef_pkg.sv]
package uef_pkg;
   // register port addresses
   localparam logic [4:0] A_RXH  = 5'h00;
   localparam logic [4:0] A_IER  = 5'h01;
   localparam logic [4:0] A_ISR  = 5'h02;
   localparam logic [4:0] A_LCR  = 5'h03;
   localparam logic [4:0] A_MCR  = 5'h04;
   localparam logic [4:0] A_LSR  = 5'h05;
   localparam logic [4:0] A_MSR  = 5'h06;
   localparam logic [4:0] A_SPR  = 5'h07;
   localparam logic [4:0] A_EFR  = 5'h08;
   localparam logic [4:0] A_FLOW_START_CHAR_ONE = 5'h09;
   localparam logic [4:0] A_FLOW_START_CHAR_TWO = 5'h0A;
   localparam logic [4:0] A_XOF1 = 5'h0B;
   localparam logic [4:0] A_XOF2 = 5'h0C;
   localparam logic [4:0] A_DLM  = 5'h0D;
   localparam logic [4:0] A_DLL  = 5'h0E;
   localparam logic [4:0] A_DLD  = 5'h0F;
   localparam logic [4:0] A_MSEL = 5'h10;
   // reset and power-up values
   localparam logic [7:0] RST_ISR  = 8'h01;
   localparam logic [7:0] RST_LSR  = 8'h60;
   localparam logic [7:0] RST_SPR  = 8'hFF;
   localparam logic [7:0] DLM_INIT = 8'h00;
   localparam logic [7:0] DLL_INIT = 8'h01;
   // field positions
   localparam int EFR_ENH  = 4;
   localparam int EFR_SPEC = 5;
   localparam int EFR_ARTS = 6;
   localparam int EFR_ACTS = 7;
   localparam int MCR_DTR  = 0;
   localparam int MCR_RTS  = 1;
   localparam int MCR_INT  = 3;
   localparam int LCR_BRK  = 6;
   localparam int IER_RX   = 0;
   localparam int IER_SPEC = 5;
   // bits that only move while enhanced mode is on
   localparam logic [7:0] IER_GATE = 8'hF0;
   localparam logic [7:0] FCR_GATE = 8'h38;
   localparam logic [7:0] MCR_GATE = 8'hE0;
   localparam logic [7:0] EFR_GATE = 8'h0F;
   // receive trigger levels and hysteresis
   localparam logic [6:0] TRIG0 = 7'h08;
   localparam logic [6:0] TRIG1 = 7'h10;
   localparam logic [6:0] TRIG2 = 7'h18;
   localparam logic [6:0] TRIG3 = 7'h1C;
   localparam logic [6:0] HYST  = 7'h04;
endpackage

// [rtl/uef_match.sv]
`timescale 1ns/1ps
module uef_match (
   // compare inputs
   input  wire logic [7:0] A,
   input  wire logic [7:0] B,
   // result
   output logic            HIT
);
   // bit 0 of the pattern lines up with the first received bit
   assign HIT = (A == B);
endmodule

// [rtl/uef_fifo.sv]
`timescale 1ns/1ps
module uef_fifo #(
   parameter int W = 8,
   parameter int D = 32
) (
   // clock and reset
   input  wire logic                 CLK,
   input  wire logic                 RESETN,
   // fill side
   input  wire logic [W-1:0]         IN_DATA,
   input  wire logic                 IN_VALID,
   output logic                      IN_READY,
   // drain side
   output logic [W-1:0]              OUT_DATA,
   output logic                      OUT_VALID,
   input  wire logic                 OUT_READY,
   // fill level
   output logic [$clog2(D+1)-1:0]    LEVEL
);
   localparam int AW = $clog2(D);
   // pointers wrap by overflow, so only powers of two are served
   if (D < 2 || (1 << AW) != D) begin : gen_bad_depth
      $error("uef_fifo depth must be a power of two");
   end
   logic [W-1:0]  mem [D];
   logic [AW-1:0] wp_ff;
   logic [AW-1:0] rp_ff;
   logic [AW:0]   cnt_ff;
   logic          push;
   logic          pop;
   assign IN_READY  = (cnt_ff != (AW+1)'(D));
   assign OUT_VALID = (cnt_ff != '0);
   assign OUT_DATA  = mem[rp_ff];
   assign LEVEL     = cnt_ff;
   assign push      = IN_VALID & IN_READY;
   assign pop       = OUT_VALID & OUT_READY;
   always_ff @(posedge CLK) begin
      if (push) begin
         mem[wp_ff] <= IN_DATA;
      end
   end
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         wp_ff  <= '0;
         rp_ff  <= '0;
         cnt_ff <= '0;
      end else begin
         wp_ff  <= wp_ff + AW'(push);
         rp_ff  <= rp_ff + AW'(pop);
         cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// [rtl/uef_top.sv]
// How it works
// - INTERRUPT_ENABLE_REG 7:4, FIFO_CONTROL_REG 5:3, MODEM_CONTROL_REG 7:5 and divisor fraction written only while enhanced is on.
// - clearing the enhanced enable freezes the enhanced configuration bits.
// - reset clears all gated enhanced bits and the divisor fraction.
// - flow select field of the enhanced register changes only while enhanced is on.
// - special detect compares each char with stop char two, stores it, sets status bit 4.
// - pair-one select: independent; pair-two: stop char two dropped, both flags raised.
// - auto request: trigger interrupt, request output high at upper hysteresis level.
// - auto request: request output low again below lower hysteresis level.
// - without auto request the pin follows its modem control bit.
// - auto clear-to-send: transmit held while the input is high.
// - four readable writable start and stop character registers.
// - multidrop mode uses stop char two as the station address.
// - divisor bytes load 0x00 high and 0x01 low at power-up only.
// - the reset pin leaves the divisor bytes untouched.
// - reset: status 0x01, line status 0x60, modem status 0x10, scratchpad 0xFF, others zero.
// - divisor fraction register writes only take effect while enhanced is on.
`timescale 1ns/1ps
module uef_top #(
   parameter int DEPTH = 32
) (
   // clock, reset, enable
   input  wire logic       CLK,
   input  wire logic       RESETN,
   input  wire logic       CE,
   // register port
   input  wire logic [4:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   output logic      [7:0] RDATA,
   // receive character stream
   input  wire logic [7:0] RX_CHAR,
   input  wire logic       RX_NINTH,
   input  wire logic       RX_VALID,
   output logic            RX_READY,
   // modem and line pins
   input  wire logic       CTS_N,
   output logic            RTS_N,
   output logic            DTR_N,
   output logic            TXD,
   output logic            TX_HOLD,
   // interrupt pin
   output logic            INT_O,
   output logic            INT_OE
);
   // level compares are seven bits wide, deeper fifos cannot be served
   if (DEPTH < 32 || DEPTH > 64) begin : gen_bad_depth
      $error("uef_top needs a depth of 32 to 64");
   end

   typedef struct packed {
      logic [7:0] interrupt_enable_reg;
      logic [7:0] fifo_control_reg;
      logic [7:0] lcr;
      logic [7:0] modem_control_reg;
      logic [7:0] scratchpad_reg;
      logic [7:0] enhanced_feature_control;
      logic [7:0] flow_start_char_one;
      logic [7:0] flow_start_char_two;
      logic [7:0] xof1;
      logic [7:0] xof2;
      logic [7:0] fractional_divisor_reg;
      logic       msel;
      logic       sp;
      logic       xf;
      logic       ovr;
      logic       dcts;
      logic       sw_stop;
      logic       addr_ok;
      logic       cts_s1;
      logic       cts_s2;
      logic       cts_prev;
      logic       rts_n;
      logic       dtr_n;
      logic       txd;
      logic       hold;
      logic       int_o;
      logic       int_oe;
      logic       rx_rdy;
      logic [7:0] rdata;
   } uef_st_t;

   typedef struct packed {
      logic [7:0] divisor_high_byte;
      logic [7:0] dll;
   } uef_div_t;

   localparam uef_st_t ST_RST = '{scratchpad_reg: uef_pkg::RST_SPR, rts_n: 1'b1, dtr_n: 1'b1,
                                  txd: 1'b1, default: '0};

   uef_st_t    s_ff;
   uef_st_t    nxt_s;
   // no reset term: only the power-up value applies
   uef_div_t   div_ff = '{divisor_high_byte: uef_pkg::DLM_INIT, dll: uef_pkg::DLL_INIT};
   uef_div_t   nxt_div;

   logic       enh;
   logic       wr;
   logic       rd;
   logic       m_on1;
   logic       m_on2;
   logic       m_of1;
   logic       m_of2;
   logic       is_on;
   logic       is_off;
   logic       spec;
   logic       take;
   logic       keep;
   logic       push;
   logic       pop;
   logic       f_rdy;
   logic       f_val;
   logic [7:0] f_data;
   logic [6:0] lvl;
   logic [6:0] lvl_n;
   logic [6:0] trig;
   logic [6:0] upper;
   logic [6:0] lower;
   logic       trig_hit;
   logic       auto_rts_n;
   logic [$clog2(DEPTH+1)-1:0] f_lvl;

   uef_match u_on1 (.A(RX_CHAR), .B(s_ff.flow_start_char_one), .HIT(m_on1));
   uef_match u_on2 (.A(RX_CHAR), .B(s_ff.flow_start_char_two), .HIT(m_on2));
   uef_match u_of1 (.A(RX_CHAR), .B(s_ff.xof1), .HIT(m_of1));
   uef_match u_of2 (.A(RX_CHAR), .B(s_ff.xof2), .HIT(m_of2));

   uef_fifo #(.W(8), .D(DEPTH)) u_fifo (
      .CLK      (CLK),
      .RESETN   (RESETN),
      .IN_DATA  (RX_CHAR),
      .IN_VALID (keep),
      .IN_READY (f_rdy),
      .OUT_DATA (f_data),
      .OUT_VALID(f_val),
      .OUT_READY(pop),
      .LEVEL    (f_lvl)
   );

   assign enh   = s_ff.enhanced_feature_control[uef_pkg::EFR_ENH];
   assign wr    = CE & WR;
   assign rd    = CE & RD;
   assign take  = CE & RX_VALID & s_ff.rx_rdy;
   assign lvl   = 7'(f_lvl);
   assign pop   = rd & (ADDR == uef_pkg::A_RXH) & f_val;

   // receive compare pair chosen by the low select bits
   always_comb begin
      is_on  = 1'b0;
      is_off = 1'b0;
      case (s_ff.enhanced_feature_control[1:0])
         2'b10: begin
            is_on  = m_on1;
            is_off = m_of1;
         end
         2'b01: begin
            is_on  = m_on2;
            is_off = m_of2;
         end
         2'b11: begin
            is_on  = m_on1 | m_on2;
            is_off = m_of1 | m_of2;
         end
         default: begin
            is_on  = 1'b0;
            is_off = 1'b0;
         end
      endcase
   end

   // address frames and flow characters never reach the fifo
   // only a character actually taken may raise the flag; the bus may hold a stale match
   assign spec  = take & s_ff.enhanced_feature_control[uef_pkg::EFR_SPEC] & m_of2 & ~(s_ff.msel & RX_NINTH);
   assign keep  = take & ~is_on & ~is_off
                & ~(s_ff.msel & (RX_NINTH | ~s_ff.addr_ok));
   assign push  = keep & f_rdy;

   always_comb begin
      case (s_ff.fifo_control_reg[7:6])
         2'b00:   trig = uef_pkg::TRIG0;
         2'b01:   trig = uef_pkg::TRIG1;
         2'b10:   trig = uef_pkg::TRIG2;
         default: trig = uef_pkg::TRIG3;
      endcase
   end

   assign upper    = trig + uef_pkg::HYST;
   assign lower    = trig - uef_pkg::HYST;
   assign trig_hit = (lvl >= trig);
   assign lvl_n    = lvl + 7'(push) - 7'(pop);

   // hysteresis: between the two levels the pin keeps its last value
   always_comb begin
      if (lvl >= upper) begin
         auto_rts_n = 1'b1;
      end else if (lvl < lower) begin
         auto_rts_n = 1'b0;
      end else begin
         auto_rts_n = s_ff.rts_n;
      end
   end

   always_comb begin
      nxt_s   = s_ff;
      nxt_div = div_ff;
      if (CE) begin
         nxt_s.cts_s1   = CTS_N;
         nxt_s.cts_s2   = s_ff.cts_s1;
         nxt_s.cts_prev = s_ff.cts_s2;
         nxt_s.rx_rdy   = (lvl_n < 7'(DEPTH));
         // a set in the same cycle as a clearing read wins
         if (rd && ADDR == uef_pkg::A_ISR) begin
            nxt_s.sp = 1'b0;
            nxt_s.xf = 1'b0;
         end
         if (rd && ADDR == uef_pkg::A_LSR) begin
            nxt_s.ovr = 1'b0;
         end
         if (rd && ADDR == uef_pkg::A_MSR) begin
            nxt_s.dcts = 1'b0;
         end
         if (s_ff.cts_s2 != s_ff.cts_prev) begin
            nxt_s.dcts = 1'b1;
         end
         if (spec) begin
            nxt_s.sp = 1'b1;
         end
         if (take && is_off) begin
            nxt_s.xf      = 1'b1;
            nxt_s.sw_stop = 1'b1;
         end
         if (take && is_on) begin
            nxt_s.sw_stop = 1'b0;
         end
         if (take && s_ff.msel && RX_NINTH) begin
            nxt_s.addr_ok = m_of2;
         end
         if (keep && !f_rdy) begin
            nxt_s.ovr = 1'b1;
         end
         if (wr) begin
            if (ADDR == uef_pkg::A_IER) begin
               nxt_s.interrupt_enable_reg = enh ? WDATA : ((s_ff.interrupt_enable_reg & uef_pkg::IER_GATE)
                         | (WDATA & ~uef_pkg::IER_GATE));
            end else if (ADDR == uef_pkg::A_ISR) begin
               nxt_s.fifo_control_reg = enh ? WDATA : ((s_ff.fifo_control_reg & uef_pkg::FCR_GATE)
                         | (WDATA & ~uef_pkg::FCR_GATE));
            end else if (ADDR == uef_pkg::A_LCR) begin
               nxt_s.lcr = WDATA;
            end else if (ADDR == uef_pkg::A_MCR) begin
               nxt_s.modem_control_reg = enh ? WDATA : ((s_ff.modem_control_reg & uef_pkg::MCR_GATE)
                         | (WDATA & ~uef_pkg::MCR_GATE));
            end else if (ADDR == uef_pkg::A_SPR) begin
               nxt_s.scratchpad_reg = WDATA;
            end else if (ADDR == uef_pkg::A_EFR) begin
               nxt_s.enhanced_feature_control = enh ? WDATA : ((s_ff.enhanced_feature_control & uef_pkg::EFR_GATE)
                         | (WDATA & ~uef_pkg::EFR_GATE));
            end else if (ADDR == uef_pkg::A_FLOW_START_CHAR_ONE) begin
               nxt_s.flow_start_char_one = WDATA;
            end else if (ADDR == uef_pkg::A_FLOW_START_CHAR_TWO) begin
               nxt_s.flow_start_char_two = WDATA;
            end else if (ADDR == uef_pkg::A_XOF1) begin
               nxt_s.xof1 = WDATA;
            end else if (ADDR == uef_pkg::A_XOF2) begin
               nxt_s.xof2 = WDATA;
            end else if (ADDR == uef_pkg::A_DLM) begin
               nxt_div.divisor_high_byte = WDATA;
            end else if (ADDR == uef_pkg::A_DLL) begin
               nxt_div.dll = WDATA;
            end else if (ADDR == uef_pkg::A_DLD && enh) begin
               nxt_s.fractional_divisor_reg = WDATA;
            end else if (ADDR == uef_pkg::A_MSEL) begin
               nxt_s.msel = WDATA[0];
            end
         end
         if (rd) begin
            if (ADDR == uef_pkg::A_RXH) begin
               nxt_s.rdata = f_val ? f_data : 8'h00;
            end else if (ADDR == uef_pkg::A_IER) begin
               nxt_s.interrupt_enable_reg   = nxt_s.interrupt_enable_reg;
               nxt_s.rdata = s_ff.interrupt_enable_reg;
            end else if (ADDR == uef_pkg::A_ISR) begin
               nxt_s.rdata = {2'b00, s_ff.xf, s_ff.sp, 1'b0, trig_hit, 1'b0, ~s_ff.int_o};
            end else if (ADDR == uef_pkg::A_LCR) begin
               nxt_s.rdata = s_ff.lcr;
            end else if (ADDR == uef_pkg::A_MCR) begin
               nxt_s.rdata = s_ff.modem_control_reg;
            end else if (ADDR == uef_pkg::A_LSR) begin
               nxt_s.rdata = (uef_pkg::RST_LSR & 8'h60) | {6'h00, s_ff.ovr, f_val};
            end else if (ADDR == uef_pkg::A_MSR) begin
               nxt_s.rdata = {3'b000, ~s_ff.cts_s2, 3'b000, s_ff.dcts};
            end else if (ADDR == uef_pkg::A_SPR) begin
               nxt_s.rdata = s_ff.scratchpad_reg;
            end else if (ADDR == uef_pkg::A_EFR) begin
               nxt_s.rdata = s_ff.enhanced_feature_control;
            end else if (ADDR == uef_pkg::A_FLOW_START_CHAR_ONE) begin
               nxt_s.rdata = s_ff.flow_start_char_one;
            end else if (ADDR == uef_pkg::A_FLOW_START_CHAR_TWO) begin
               nxt_s.rdata = s_ff.flow_start_char_two;
            end else if (ADDR == uef_pkg::A_XOF1) begin
               nxt_s.rdata = s_ff.xof1;
            end else if (ADDR == uef_pkg::A_XOF2) begin
               nxt_s.rdata = s_ff.xof2;
            end else if (ADDR == uef_pkg::A_DLM) begin
               nxt_s.rdata = div_ff.divisor_high_byte;
            end else if (ADDR == uef_pkg::A_DLL) begin
               nxt_s.rdata = div_ff.dll;
            end else if (ADDR == uef_pkg::A_DLD) begin
               nxt_s.rdata = s_ff.fractional_divisor_reg;
            end else if (ADDR == uef_pkg::A_MSEL) begin
               nxt_s.rdata = {7'h00, s_ff.msel};
            end else begin
               nxt_s.rdata = 8'h00;
            end
         end
         // auto mode only acts once software has asserted the request bit
         if (s_ff.enhanced_feature_control[uef_pkg::EFR_ARTS]) begin
            nxt_s.rts_n = s_ff.modem_control_reg[uef_pkg::MCR_RTS] ? auto_rts_n : 1'b1;
         end else begin
            nxt_s.rts_n = ~s_ff.modem_control_reg[uef_pkg::MCR_RTS];
         end
         nxt_s.dtr_n  = ~s_ff.modem_control_reg[uef_pkg::MCR_DTR];
         nxt_s.txd    = ~s_ff.lcr[uef_pkg::LCR_BRK];
         nxt_s.hold   = (s_ff.enhanced_feature_control[uef_pkg::EFR_ACTS] & s_ff.cts_s2) | s_ff.sw_stop;
         nxt_s.int_o  = ((s_ff.sp | s_ff.xf) & s_ff.interrupt_enable_reg[uef_pkg::IER_SPEC])
                      | (trig_hit & s_ff.interrupt_enable_reg[uef_pkg::IER_RX]);
         nxt_s.int_oe = s_ff.modem_control_reg[uef_pkg::MCR_INT];
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         s_ff <= ST_RST;
      end else begin
         s_ff <= nxt_s;
      end
   end

   always_ff @(posedge CLK) begin
      div_ff <= nxt_div;
   end

   assign RDATA    = s_ff.rdata;
   assign RX_READY = s_ff.rx_rdy;
   assign RTS_N    = s_ff.rts_n;
   assign DTR_N    = s_ff.dtr_n;
   assign TXD      = s_ff.txd;
   assign TX_HOLD  = s_ff.hold;
   assign INT_O    = s_ff.int_o;
   assign INT_OE   = s_ff.int_oe;

   property p_ier_gate;
      @(posedge CLK) disable iff (!RESETN)
      (wr && ADDR == uef_pkg::A_IER && !enh) |=> (s_ff.interrupt_enable_reg[7:4] == $past(s_ff.interrupt_enable_reg[7:4]));
   endproperty
   a_ier_gate: assert property (p_ier_gate) else $error("ier upper bits changed while locked");

   property p_mcr_gate;
      @(posedge CLK) disable iff (!RESETN)
      (wr && ADDR == uef_pkg::A_MCR && !enh) |=> (s_ff.modem_control_reg[7:5] == $past(s_ff.modem_control_reg[7:5]));
   endproperty
   a_mcr_gate: assert property (p_mcr_gate) else $error("mcr upper bits changed while locked");

   property p_efr_sel;
      @(posedge CLK) disable iff (!RESETN)
      (wr && ADDR == uef_pkg::A_EFR && !enh) |=> $stable(s_ff.enhanced_feature_control[3:0]);
   endproperty
   a_efr_sel: assert property (p_efr_sel) else $error("flow select changed while locked");

   property p_dld_lock;
      @(posedge CLK) disable iff (!RESETN)
      (!enh && !$past(enh)) |-> $stable(s_ff.fractional_divisor_reg);
   endproperty
   a_dld_lock: assert property (p_dld_lock) else $error("divisor fraction changed while locked");

   property p_spec_set;
      @(posedge CLK) disable iff (!RESETN)
      (take && s_ff.enhanced_feature_control[5] && m_of2 && !s_ff.msel) |=> s_ff.sp;
   endproperty
   a_spec_set: assert property (p_spec_set) else $error("special flag not set on match");

   property p_x2_drop;
      @(posedge CLK) disable iff (!RESETN)
      (take && s_ff.enhanced_feature_control[1:0] == 2'b01 && m_of2) |-> (!push ##1 (s_ff.xf && s_ff.sw_stop));
   endproperty
   a_x2_drop: assert property (p_x2_drop) else $error("stop char two stored or no flag");

   property p_rts_high;
      @(posedge CLK) disable iff (!RESETN)
      (CE && s_ff.enhanced_feature_control[6] && s_ff.modem_control_reg[1] && lvl >= upper) |=> RTS_N;
   endproperty
   a_rts_high: assert property (p_rts_high) else $error("request not released at upper level");

   property p_rts_low;
      @(posedge CLK) disable iff (!RESETN)
      (CE && s_ff.enhanced_feature_control[6] && s_ff.modem_control_reg[1] && lvl < lower) |=> !RTS_N;
   endproperty
   a_rts_low: assert property (p_rts_low) else $error("request not asserted below lower level");

   property p_rts_gpo;
      @(posedge CLK) disable iff (!RESETN)
      (CE && !s_ff.enhanced_feature_control[6]) |=> (RTS_N == !$past(s_ff.modem_control_reg[1]));
   endproperty
   a_rts_gpo: assert property (p_rts_gpo) else $error("request pin not following mcr");

   property p_cts_hold;
      @(posedge CLK) disable iff (!RESETN)
      (CE && s_ff.enhanced_feature_control[7] && s_ff.cts_s2) |=> TX_HOLD;
   endproperty
   a_cts_hold: assert property (p_cts_hold) else $error("transmit not held on clear-to-send high");
endmodule

// [test/uef_remote.sv]
`timescale 1ns/1ps
module uef_remote (
   // clock
   input  wire logic clk,
   // bench control
   input  wire logic throttle,
   // modem line
   output logic      cts_n
);
   initial cts_n = 1'b0;
   // far side moves its pin away from the sampling edge
   always @(negedge clk) begin
      cts_n <= throttle;
   end
endmodule

// [test/uef_top_test.sv]
`timescale 1ns/1ps
module uef_top_test;
   logic       CLK;
   logic       RESETN;
   logic       WR;
   logic       RD;
   logic       RX_VALID;
   logic       RX_NINTH;
   logic       throttle;
   logic       cts_n;
   logic [4:0] ADDR;
   logic [7:0] WDATA;
   logic [7:0] RX_CHAR;
   logic [7:0] RDATA;
   logic       RX_READY;
   logic       RTS_N;
   logic       DTR_N;
   logic       TXD;
   logic       TX_HOLD;
   logic       INT_O;
   logic       INT_OE;
   logic [7:0] v;
   int         errors;
   int         checks;
   int         cycles;
   int         n;

   uef_top #(.DEPTH(32)) uef_top_inst (.CLK(CLK), .RESETN(RESETN), .CE(1'b1), .ADDR(ADDR), .WDATA(WDATA),
      .WR(WR), .RD(RD), .RDATA(RDATA), .RX_CHAR(RX_CHAR), .RX_NINTH(RX_NINTH), .RX_VALID(RX_VALID),
      .RX_READY(RX_READY), .CTS_N(cts_n), .RTS_N(RTS_N), .DTR_N(DTR_N), .TXD(TXD), .TX_HOLD(TX_HOLD),
      .INT_O(INT_O), .INT_OE(INT_OE));
   uef_remote uef_remote_inst (.clk(CLK), .throttle(throttle), .cts_n(cts_n));

   initial begin
      CLK = 1'b0;
      forever #20 CLK = ~CLK;
   end

   // whole run needs about 430 cycles
   always @(posedge CLK) begin
      cycles++;
      if (cycles == 8000) begin
         errors++;
         conclude();
      end
   end

   task automatic conclude();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic cmp(input string nm, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic idle(input int k);
      repeat (k) @(negedge CLK);
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(negedge CLK);
      ADDR = a;
      WDATA = d;
      WR = 1'b1;
      @(negedge CLK);
      WR = 1'b0;
   endtask

   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      @(negedge CLK);
      ADDR = a;
      RD = 1'b1;
      @(negedge CLK);
      RD = 1'b0;
      d = RDATA;
   endtask

   task automatic chk(input string nm, input logic [4:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      cmp(nm, exp, d);
   endtask

   task automatic push(input logic [7:0] c);
      @(negedge CLK);
      RX_CHAR = c;
      RX_VALID = 1'b1;
      @(negedge CLK);
      RX_VALID = 1'b0;
   endtask

   // address frame of the multidrop protocol
   task automatic push9(input logic [7:0] c);
      RX_NINTH = 1'b1;
      push(c);
      RX_NINTH = 1'b0;
   endtask

   task automatic do_reset();
      @(negedge CLK);
      RESETN = 1'b0;
      idle(20);
      RESETN = 1'b1;
      idle(1);
   endtask

   task automatic t_reset();
      chk("isr", uef_pkg::A_ISR, uef_pkg::RST_ISR);
      chk("lsr", uef_pkg::A_LSR, uef_pkg::RST_LSR);
      chk("spr", uef_pkg::A_SPR, uef_pkg::RST_SPR);
      chk("efr", uef_pkg::A_EFR, 8'h00);
      chk("dld", uef_pkg::A_DLD, 8'h00);
      chk("dlm", uef_pkg::A_DLM, uef_pkg::DLM_INIT);
      chk("dll", uef_pkg::A_DLL, uef_pkg::DLL_INIT);
      cmp("pins", 8'h07, {5'h00, RTS_N, DTR_N, TXD});
      cmp("int_oe", 8'h00, {7'h00, INT_OE});
      $display("test reset done");
   endtask

   task automatic t_gate();
      wr(uef_pkg::A_IER, 8'hFF);
      chk("ier off", uef_pkg::A_IER, 8'h0F);
      // select field is still locked here, only the enable lands
      wr(uef_pkg::A_EFR, 8'h1F);
      chk("efr locked", uef_pkg::A_EFR, 8'h10);
      wr(uef_pkg::A_EFR, 8'h1F);
      chk("efr on", uef_pkg::A_EFR, 8'h1F);
      wr(uef_pkg::A_IER, 8'hF0);
      wr(uef_pkg::A_MCR, 8'hE0);
      wr(uef_pkg::A_DLD, 8'hA5);
      wr(uef_pkg::A_DLM, 8'h5A);
      chk("dld on", uef_pkg::A_DLD, 8'hA5);
      wr(uef_pkg::A_EFR, 8'h0F);
      wr(uef_pkg::A_EFR, 8'h00);
      chk("efr off", uef_pkg::A_EFR, 8'h0F);
      wr(uef_pkg::A_IER, 8'h00);
      wr(uef_pkg::A_MCR, 8'h00);
      wr(uef_pkg::A_DLD, 8'h00);
      chk("ier held", uef_pkg::A_IER, 8'hF0);
      chk("mcr held", uef_pkg::A_MCR, 8'hE0);
      chk("dld held", uef_pkg::A_DLD, 8'hA5);
      do_reset();
      chk("ier rst", uef_pkg::A_IER, 8'h00);
      chk("dld rst", uef_pkg::A_DLD, 8'h00);
      chk("dlm kept", uef_pkg::A_DLM, 8'h5A);
      $display("test gate done");
   endtask

   task automatic t_chars();
      for (int i = 0; i < 4; i++) wr(uef_pkg::A_FLOW_START_CHAR_ONE + 5'(i), 8'h3C ^ 8'(i * 17));
      for (int i = 0; i < 4; i++) chk("flow char", uef_pkg::A_FLOW_START_CHAR_ONE + 5'(i), 8'h3C ^ 8'(i * 17));
      $display("test chars done");
   endtask

   task automatic t_special();
      wr(uef_pkg::A_EFR, 8'h30);
      wr(uef_pkg::A_XOF2, 8'h55);
      push(8'h54);
      rd(uef_pkg::A_ISR, v);
      cmp("no match", 8'h00, {7'h00, v[4]});
      push(8'h55);
      rd(uef_pkg::A_ISR, v);
      cmp("match", 8'h01, {7'h00, v[4]});
      // the matching char still sits on the bus, but nothing new was taken
      rd(uef_pkg::A_ISR, v);
      cmp("cleared", 8'h00, {7'h00, v[4]});
      chk("rx 1", uef_pkg::A_RXH, 8'h54);
      chk("rx 2", uef_pkg::A_RXH, 8'h55);
      wr(uef_pkg::A_EFR, 8'h31);
      push(8'h55);
      push(8'h56);
      rd(uef_pkg::A_ISR, v);
      cmp("pair two", 8'h03, {6'h00, v[5:4]});
      chk("dropped", uef_pkg::A_RXH, 8'h56);
      cmp("sw hold", 8'h01, {7'h00, TX_HOLD});
      // pair one: stop char two is an ordinary char again
      wr(uef_pkg::A_EFR, 8'h32);
      push(8'h55);
      push(8'h1E);
      chk("pair one", uef_pkg::A_RXH, 8'h55);
      // either pair: start char two is swallowed and releases the hold
      wr(uef_pkg::A_EFR, 8'h33);
      push(8'h2D);
      chk("both empty", uef_pkg::A_LSR, uef_pkg::RST_LSR);
      cmp("sw resume", 8'h00, {7'h00, TX_HOLD});
      $display("test special done");
   endtask

   task automatic t_rts();
      do_reset();
      wr(uef_pkg::A_MCR, 8'h02);
      idle(2);
      cmp("rts gp low", 8'h00, {7'h00, RTS_N});
      wr(uef_pkg::A_MCR, 8'h00);
      idle(2);
      cmp("rts gp high", 8'h01, {7'h00, RTS_N});
      wr(uef_pkg::A_EFR, 8'h50);
      idle(2);
      cmp("auto unarmed", 8'h01, {7'h00, RTS_N});
      wr(uef_pkg::A_MCR, 8'h02);
      for (int i = 0; i < 11; i++) push(8'(i));
      idle(2);
      cmp("rts below", 8'h00, {7'h00, RTS_N});
      push(8'd11);
      idle(2);
      cmp("rts upper", 8'h01, {7'h00, RTS_N});
      rd(uef_pkg::A_ISR, v);
      cmp("trigger", 8'h01, {7'h00, v[2]});
      wr(uef_pkg::A_IER, 8'h01);
      wr(uef_pkg::A_MCR, 8'h0B);
      idle(2);
      cmp("int pins", 8'h03, {5'h00, DTR_N, INT_OE, INT_O});
      n = 12;
      while (RX_READY === 1'b1 && n < 40) begin
         push(8'(n));
         n++;
      end
      cmp("fill count", 8'd32, 8'(n));
      for (int i = 0; i < 32; i++) begin
         if (i == 28) cmp("rts at four", 8'h01, {7'h00, RTS_N});
         if (i == 29) cmp("rts lower", 8'h00, {7'h00, RTS_N});
         chk("drain", uef_pkg::A_RXH, 8'(i));
         idle(1);
      end
      $display("test rts done");
   endtask

   task automatic t_cts();
      do_reset();
      wr(uef_pkg::A_EFR, 8'h90);
      throttle = 1'b1;
      idle(5);
      cmp("hold on", 8'h01, {7'h00, TX_HOLD});
      throttle = 1'b0;
      idle(5);
      cmp("hold off", 8'h00, {7'h00, TX_HOLD});
      wr(uef_pkg::A_EFR, 8'h10);
      throttle = 1'b1;
      idle(5);
      cmp("hold unused", 8'h00, {7'h00, TX_HOLD});
      throttle = 1'b0;
      $display("test cts done");
   endtask

   task automatic t_multi();
      wr(uef_pkg::A_MSEL, 8'h01);
      wr(uef_pkg::A_XOF2, 8'h7E);
      push(8'h41);
      push9(8'h7E);
      push(8'h42);
      push9(8'h33);
      push(8'h43);
      chk("addressed", uef_pkg::A_RXH, 8'h42);
      chk("not addressed", uef_pkg::A_LSR, uef_pkg::RST_LSR);
      $display("test multidrop done");
   endtask

   initial begin
      RESETN = 1'b0;
      WR = 1'b0;
      RD = 1'b0;
      RX_VALID = 1'b0;
      RX_NINTH = 1'b0;
      RX_CHAR = 8'h00;
      ADDR = 5'h00;
      WDATA = 8'h00;
      throttle = 1'b0;
      idle(20);
      RESETN = 1'b1;
      idle(1);
      t_reset();
      t_gate();
      t_chars();
      t_special();
      t_rts();
      t_cts();
      t_multi();
      conclude();
   end
endmodule
